// >>> design/dac_link_map.svh
// Constants for the serial converter write host
`ifndef DAC_LINK_MAP_SVH
`define DAC_LINK_MAP_SVH
`define WORD_BITS      19
`define CHAN_BITS      5
`define CODE_BITS      14
`define BYTE_BITS      8
`define BYTES_PER_WORD 3
`define PAD_BITS       5
`define CLK_HALF_CYC   4
`define GAP_NS         280
`define SYS_PERIOD_NS  100
`define GAP_CYC        ((`GAP_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
`endif

// >>> design/dac_link_pkg.sv
// Types for the serial converter write host
package dac_link_pkg;
  typedef struct packed {
    logic [4:0]  channel_select_field;
    logic [13:0] channel_code_field;
  } command_t;

  typedef struct packed {
    logic sclk;
    logic din;
    logic frame_b;
  } link_pins_t;
endpackage : dac_link_pkg

// >>> design/cmd_skid_buf.sv
// Two-entry command buffer with valid and ready on both sides
`timescale 1ns/1ps
module cmd_skid_buf (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  input  wire dac_link_pkg::command_t in_data,
  input  wire logic                   in_valid,
  output logic                        in_ready,
  output dac_link_pkg::command_t      out_data,
  output logic                        out_valid,
  input  wire logic                   out_ready
);
  dac_link_pkg::command_t mem [0:1];
  dac_link_pkg::command_t next_mem [0:1];
  logic [1:0] count;
  logic [1:0] next_count;
  logic       rd_ptr;
  logic       next_rd_ptr;
  logic       push;
  logic       pop;
  logic       next_in_ready;

  assign out_valid = (count != 2'h0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_mem[0] = mem[0];
    next_mem[1] = mem[1];
    next_count  = count;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_mem[rd_ptr ^ count[0]] = in_data;
    end
    if (pop) begin
      next_rd_ptr = ~rd_ptr;
    end
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
    // Ready leaves a flop so the port is glitch free
    next_in_ready = (next_count != 2'h2);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      count    <= 2'h0;
      rd_ptr   <= 1'b0;
      in_ready <= 1'b1;
      mem[0]   <= '0;
      mem[1]   <= '0;
    end else begin
      in_ready <= next_in_ready;
      count  <= next_count;
      rd_ptr <= next_rd_ptr;
      mem[0] <= next_mem[0];
      mem[1] <= next_mem[1];
    end
  end
endmodule : cmd_skid_buf

// >>> design/dac_write_host.sv
// Host that writes 19-bit channel commands to the serial converter port
//
// Function
// - The host is clock master and its shift clock idles low.
// - A word goes out as three back-to-back byte transfers.
// - Bits are sent most significant first.
// - The word is left-justified: 19 valid bits first, padding after.
// - The frame line is driven low before the first clock of a word.
// - Between words the frame line returns high and then goes low again.
// - The shift clock is synchronous with the data it carries.
// - Clock sense is such that data is stable at the falling edge.
// - A least-significant-first port would reverse bits; this one is not.
// - The frame line is a separate port output pulsed per word.
// - A word is a 5-bit channel select then a 14-bit code.
`timescale 1ns/1ps
`include "dac_link_map.svh"
module dac_write_host (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  input  wire dac_link_pkg::command_t cmd_data,
  input  wire logic                   cmd_valid,
  output logic                        cmd_ready,
  output logic                        sclk,
  output logic                        din,
  output logic                        host_frame_port_pin,
  output logic                        busy
);
  typedef enum logic [2:0] {IDLE, SETUP, LOW, HIGH, GAP, DONE} state_t;

  // Sequencer state
  state_t      state;
  state_t      next_state;
  logic [23:0] shreg;
  logic [23:0] next_shreg;
  logic [2:0]  bit_cnt;
  logic [2:0]  next_bit_cnt;
  logic [1:0]  byte_cnt;
  logic [1:0]  next_byte_cnt;
  logic [2:0]  tick;
  logic [2:0]  next_tick;

  // Pin state
  logic        next_sclk;
  logic        next_din;
  logic        next_frame;
  logic        next_busy;

  // Events handed from the sequencer to the pin group; all but in_gap and half_done last one cycle
  logic        start_word;
  logic        half_done;
  logic        rise_now;
  logic        fall_now;
  logic        last_fall;
  logic        in_gap;
  logic        gap_done;

  dac_link_pkg::command_t buf_data;
  logic                   buf_valid;
  logic                   buf_take;

  cmd_skid_buf u_buf (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .in_data   (cmd_data),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (buf_take)
  );

  // The buffer is drained only between words
  assign buf_take   = (state == IDLE);
  assign start_word = (state == IDLE) && buf_valid;
  assign half_done  = (tick == 3'(`CLK_HALF_CYC - 1));
  assign rise_now   = (state == LOW) && half_done;
  assign fall_now   = (state == HIGH) && half_done;
  assign last_fall  = fall_now && (bit_cnt == 3'(`BYTE_BITS - 1)) &&
                      (byte_cnt == 2'(`BYTES_PER_WORD - 1));
  assign in_gap     = (state == GAP);
  assign gap_done   = in_gap && (tick == 3'(`GAP_CYC - 1));

  // Sequencer: bit timing, bit and byte counts, shift register
  always_comb begin
    next_state    = state;
    next_shreg    = shreg;
    next_bit_cnt  = bit_cnt;
    next_byte_cnt = byte_cnt;
    next_tick     = tick;
    unique case (state)
      IDLE: begin
        if (start_word) begin
          // Word left-justified in three bytes, pad at the tail
          next_shreg    = {buf_data, {`PAD_BITS{1'b0}}};
          next_tick     = 3'h0;
          next_bit_cnt  = 3'h0;
          next_byte_cnt = 2'h0;
          next_state    = SETUP;
        end
      end
      SETUP: begin
        next_tick  = 3'h0;
        next_state = LOW;
      end
      LOW: begin
        next_tick = tick + 3'h1;
        if (rise_now) begin
          next_tick  = 3'h0;
          next_state = HIGH;
        end
      end
      HIGH: begin
        next_tick = tick + 3'h1;
        if (fall_now) begin
          // Bit just captured by the device, move the next one up
          next_tick    = 3'h0;
          next_shreg   = {shreg[22:0], 1'b0};
          next_bit_cnt = bit_cnt + 3'h1;
          next_state   = LOW;
          if (bit_cnt == 3'(`BYTE_BITS - 1)) begin
            next_bit_cnt  = 3'h0;
            next_byte_cnt = byte_cnt + 2'h1;
          end
          if (last_fall) begin
            next_state = GAP;
          end
        end
      end
      GAP: begin
        next_tick = tick + 3'h1;
        if (gap_done) begin
          next_state = DONE;
        end
      end
      DONE: begin
        next_state = IDLE;
      end
      default: begin
        next_state = IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state    <= IDLE;
      shreg    <= 24'h000000;
      bit_cnt  <= 3'h0;
      byte_cnt <= 2'h0;
      tick     <= 3'h0;
    end else begin
      state    <= next_state;
      shreg    <= next_shreg;
      bit_cnt  <= next_bit_cnt;
      byte_cnt <= next_byte_cnt;
      tick     <= next_tick;
    end
  end

  // Pin group: from the first rise to the last fall, data moves only with the rising clock edge, so it stays
  // steady across the falling edge at which the device captures it
  always_comb begin
    next_sclk  = sclk;
    next_din   = din;
    next_frame = host_frame_port_pin;
    next_busy  = busy;
    if (start_word) begin
      next_frame = 1'b0;
      next_busy  = 1'b1;
    end
    if (state == SETUP) begin
      // First bit set up a full half period before the first rise
      next_din = shreg[23];
    end
    if (rise_now) begin
      next_sclk = 1'b1;
      next_din  = shreg[23];
    end
    if (fall_now) begin
      next_sclk = 1'b0;
    end
    if (in_gap) begin
      // Frame high with the clock parked low before the next word
      next_frame = 1'b1;
      next_din   = 1'b0;
    end
    if (state == IDLE) begin
      next_sclk = 1'b0;
    end
    if (state == DONE) begin
      next_busy = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sclk                <= 1'b0;
      din                 <= 1'b0;
      host_frame_port_pin <= 1'b1;
      busy                <= 1'b0;
    end else begin
      sclk                <= next_sclk;
      din                 <= next_din;
      host_frame_port_pin <= next_frame;
      busy                <= next_busy;
    end
  end
endmodule : dac_write_host

// >>> tb/host_link_assertions.sv
// Pin checks for the serial write host
`timescale 1ns/1ps
module host_link_checker (
  input wire logic                   sys_clk,
  input wire logic                   rst_b,
  input wire dac_link_pkg::command_t cmd_data,
  input wire logic                   cmd_valid,
  input wire logic                   cmd_ready,
  input wire logic                   sclk,
  input wire logic                   din,
  input wire logic                   host_frame_port_pin,
  input wire logic                   busy
);
  logic [4:0] rises;
  logic       sclk_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Counts shift-clock rises inside one frame
  always_ff @(posedge sys_clk) begin
    sclk_q <= sclk;
    if (!rst_b || host_frame_port_pin)
      rises <= 5'h00;
    else if (sclk && !sclk_q)
      rises <= rises + 5'h01;
  end
  sequence high_phase;
    sclk [*4] ##1 !sclk;
  endsequence
  // Data launched with the rise holds through the sample after the fall
  sequence data_held;
    $stable(din) [*4];
  endsequence
  idle_clock_a: assert property (host_frame_port_pin |-> !sclk)
    else $error("clock not low outside frame");
  frame_lead_a: assert property (
    $fell(host_frame_port_pin) |-> !sclk [*4])
    else $error("clock too soon after frame");
  clock_framed_a: assert property (
    $rose(sclk) |-> !host_frame_port_pin)
    else $error("clock edge outside frame");
  half_period_a: assert property ($rose(sclk) |-> high_phase)
    else $error("clock high phase wrong");
  data_steady_a: assert property (
    $rose(sclk) |=> data_held)
    else $error("data moved before falling edge");
  word_bits_a: assert property (
    $rose(host_frame_port_pin) |-> rises == 5'h18)
    else $error("frame not 24 clocks");
  pad_zero_a: assert property (sclk && rises > 5'h13 |-> !din)
    else $error("padding not zero");
  frame_gap_a: assert property (
    $rose(host_frame_port_pin) |-> host_frame_port_pin [*3])
    else $error("frame gap short");
  busy_frame_a: assert property (!host_frame_port_pin |-> busy)
    else $error("frame low while not busy");
endmodule : host_link_checker

bind dac_write_host host_link_checker chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .sclk(sclk), .din(din), .host_frame_port_pin(host_frame_port_pin),
  .busy(busy));

// >>> tb/dac_device_model.sv
// Behavioural converter that takes words off the link
`timescale 1ns/1ps
module dac_device_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic din,
  input wire logic frame_b
);
  logic [13:0] chan_reg [32];
  logic [18:0] word;
  logic [4:0]  cnt;
  logic        sclk_q;
  logic        frame_q;
  logic        done;
  always_ff @(posedge sys_clk) begin
    sclk_q  <= sclk;
    frame_q <= frame_b;
    done    <= 1'b0;
    if (!rst_b) begin
      cnt <= 5'h13;
      for (int i = 0; i < 32; i++)
        chan_reg[i] <= 14'h0000;
    end else if (frame_q && !frame_b && cnt == 5'h13) begin
      cnt <= 5'h00;
    end else if (sclk_q && !sclk && !frame_b && cnt < 5'h13) begin
      word <= {word[17:0], din};
      cnt  <= cnt + 5'h01;
      if (cnt == 5'h12) begin
        done <= 1'b1;
        chan_reg[word[17:13]] <= {word[12:0], din};
      end
    end
  end
endmodule : dac_device_model

// >>> tb/dac_write_host_tb.sv
// Self-checking bench for the serial write host
`timescale 1ns/1ps
module dac_write_host_tb;
  logic                   sys_clk;
  logic                   rst_b;
  dac_link_pkg::command_t cmd_data;
  logic                   cmd_valid;
  logic                   cmd_ready;
  logic                   sclk;
  logic                   din;
  logic                   frame_b;
  logic                   busy;
  logic [31:0]            seed;
  logic [18:0]            exp_q[$];
  logic [18:0]            exp_w;
  int                     mismatches;
  int                     compares;
  dac_write_host uut (.sys_clk(sys_clk), .rst_b(rst_b), .cmd_data(cmd_data),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .sclk(sclk), .din(din),
    .host_frame_port_pin(frame_b), .busy(busy));
  dac_device_model dev (.sys_clk(sys_clk), .rst_b(rst_b), .sclk(sclk),
    .din(din), .frame_b(frame_b));
  function automatic logic [31:0] xorshift(logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xorshift
  task automatic check(string what, logic [18:0] seen, logic [18:0] want);
    compares++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // Holds the offer until the buffer takes it
  task automatic send(logic [18:0] w);
    int   n;
    logic ok;
    @(negedge sys_clk);
    cmd_data  <= w;
    cmd_valid <= 1'b1;
    for (n = 0; n < 4000; n++) begin
      if (n > 0)
        @(negedge sys_clk);
      // Ready is settled mid-cycle; the taking edge is the next rise
      ok = (cmd_ready === 1'b1);
      @(posedge sys_clk);
      if (ok)
        break;
    end
    if (n == 4000) begin
      mismatches++;
      summarize();
    end
    exp_q.push_back(w);
  endtask : send
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    if (dev.done === 1'b1) begin
      check("queued", {18'h00000, exp_q.size() != 0}, 19'h00001);
      if (exp_q.size() != 0) begin
        exp_w = exp_q.pop_front();
        check("word", dev.word, exp_w);
        check("chan", {5'h00, dev.chan_reg[exp_w[18:14]]},
          {5'h00, exp_w[13:0]});
      end
    end
  end
  initial begin
    int n;
    rst_b      = 1'b0;
    cmd_data   = '0;
    cmd_valid  = 1'b0;
    seed       = 32'h00003FEB;
    mismatches = 0;
    compares   = 0;
    repeat (3) @(negedge sys_clk);
    rst_b <= 1'b1;
    check("idle", {15'h0000, busy, sclk, frame_b, cmd_ready},
      19'h00003);
    check("zero", {5'h00, dev.chan_reg[7]}, 19'h00000);
    $display("test reset done");
    send(19'h7FFFF);
    send(19'h00000);
    for (n = 0; n < 6; n++) begin
      seed = xorshift(seed);
      send(seed[18:0]);
    end
    @(negedge sys_clk);
    cmd_valid <= 1'b0;
    for (n = 0; n < 20000 && exp_q.size() > 0; n++)
      @(negedge sys_clk);
    if (exp_q.size() > 0)
      mismatches++;
    $display("test burst done");
    summarize();
  end
endmodule : dac_write_host_tb
